// file: hw/vcs_channel.v
// one capture channel status word: position, sync and completion flags
`timescale 1ns/1ps
module vcs_channel
(
   input wire clk,
   input wire rst_b,
   input wire ce,
   input wire raw_mode,
   input wire hold_mode,
   input wire sync_line_select,
   input wire [11:0] field1_irq_line,
   input wire [11:0] field2_irq_line,
   input wire [11:0] pixel_counter,
   input wire [11:0] line_counter,
   input wire [23:0] sample_counter,
   input wire active_field,
   input wire frame_done,
   input wire field1_done,
   input wire field2_done,
   input wire clr_wr,
   input wire [2:0] clr_bits,
   output wire [31:0] status,
   output wire [2:0] done_pulse,
   output wire capture_allow
);
`include "vcs_defines.vh"
reg frame_sync_flag;
reg frame_done_flag;
reg field1_done_flag;
reg field2_done_flag;
reg active_field_flag;
reg [11:0] horiz_position;
reg [11:0] vert_position;
wire [11:0] sync_end_line;
wire vid;
assign vid = (raw_mode == `VCS_MODE_VIDEO);
assign sync_end_line = sync_line_select ? field2_irq_line : field1_irq_line;
assign done_pulse = {frame_done, vid & field2_done, vid & field1_done};
// software must drain the flags before more capture in hold mode
assign capture_allow = ~hold_mode |
   ~(frame_done_flag | field1_done_flag | field2_done_flag);
// bits 15..13 are tied low here, so writes never reach them
assign status = {frame_sync_flag, frame_done_flag, field2_done_flag,
   field1_done_flag, vert_position, 3'b000, active_field_flag,
   horiz_position};
always @(posedge clk)
begin
   if (!rst_b)
   begin
      frame_sync_flag <= 1'b0;
      frame_done_flag <= 1'b0;
      field1_done_flag <= 1'b0;
      field2_done_flag <= 1'b0;
      active_field_flag <= 1'b0;
      horiz_position <= 12'h000;
      vert_position <= 12'h000;
   end
   else if (ce)
   begin
      if (vid)
      begin
         horiz_position <= pixel_counter;
         vert_position <= line_counter;
         active_field_flag <= active_field;
         if (line_counter == `VCS_LINE_ONE && !active_field)
            frame_sync_flag <= 1'b1;
         else if (line_counter == sync_end_line)
            frame_sync_flag <= 1'b0;
      end
      else
      begin
         horiz_position <= sample_counter[11:0];
         vert_position <= sample_counter[23:12];
         active_field_flag <= 1'b0;
         frame_sync_flag <= 1'b0;
      end
      // set is ordered after clear so a same-cycle event survives
      if (clr_wr && clr_bits[2])
         frame_done_flag <= 1'b0;
      if (frame_done)
         frame_done_flag <= 1'b1;
      if (clr_wr && clr_bits[1])
         field2_done_flag <= 1'b0;
      if (vid && field2_done)
         field2_done_flag <= 1'b1;
      if (clr_wr && clr_bits[0])
         field1_done_flag <= 1'b0;
      if (vid && field1_done)
         field1_done_flag <= 1'b1;
   end
end
endmodule

// file: hw/vcs_defines.vh
// register map, field positions and reset values of the capture status bank
`ifndef VCS_DEFINES_VH
`define VCS_DEFINES_VH
`define VCS_ADDR_W 4
`define VCS_OFF_STAT_A 4'h0
`define VCS_OFF_STAT_B 4'h1
`define VCS_OFF_CTRL 4'h2
`define VCS_OFF_IRQ_STAT 4'h3
`define VCS_OFF_IRQ_EN 4'h4
`define VCS_OFF_IRQ_CLR 4'h5
`define VCS_BIT_SYNC 31
`define VCS_BIT_FRAME 30
`define VCS_BIT_F2 29
`define VCS_BIT_F1 28
`define VCS_BIT_FIELD 12
`define VCS_RST_STAT 32'h00000000
`define VCS_RST_CTRL 32'h00000000
`define VCS_LINE_ONE 12'h001
`define VCS_MODE_VIDEO 1'b0
`endif

// file: hw/vcs_top.v
// capture status bank for two channels with an avalon-mm slave
//
// Summary of operation
// - video modes show pixel counter low and line counter high.
// - raw and stream modes show the 24-bit sample count split in halves.
// - sync flag sets at line 1 of field 1, clears at selected irq line.
// - frame done flag sets after whole frame, block or packet.
// - field 2 done flag sets in video modes only.
// - field 1 done flag sets in video modes only.
// - done flags clear on written one; other fields ignore writes.
// - every status field reads zero after reset.
// - bits 15 to 13 read zero and ignore writes.
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module vcs_top
(
   input wire clk,
   input wire rst_b,
   input wire ce,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   output wire irq,
   input wire [11:0] a_pixel_counter,
   input wire [11:0] a_line_counter,
   input wire [23:0] a_sample_counter,
   input wire a_active_field,
   input wire a_frame_done,
   input wire a_field1_done,
   input wire a_field2_done,
   input wire [11:0] a_field1_irq_line,
   input wire [11:0] a_field2_irq_line,
   input wire a_sync_line_select,
   output wire a_capture_allow,
   input wire [11:0] b_pixel_counter,
   input wire [11:0] b_line_counter,
   input wire [23:0] b_sample_counter,
   input wire b_active_field,
   input wire b_frame_done,
   input wire b_field1_done,
   input wire b_field2_done,
   input wire [11:0] b_field1_irq_line,
   input wire [11:0] b_field2_irq_line,
   input wire b_sync_line_select,
   output wire b_capture_allow
);
`include "vcs_defines.vh"
// ctrl: bit0 a raw/stream mode, bit1 a hold mode, bit2/3 same for b
reg [3:0] ctrl;
reg [5:0] irq_status;
reg [5:0] irq_enable;
reg ack;
wire [31:0] stat_a;
wire [31:0] stat_b;
wire [2:0] pulse_a;
wire [2:0] pulse_b;
wire req;
wire wr_go;
wire rd_go;
wire hit_a;
wire hit_b;
wire [5:0] irq_clr;
// one wait state: the answer comes on the second edge of a request
assign req = avs_read | avs_write;
assign avs_waitrequest = req & ~ack;
assign wr_go = avs_write & ack & ce;
assign rd_go = avs_read & ~ack & ce;
assign hit_a = wr_go && avs_address == `VCS_OFF_STAT_A &&
   avs_byteenable[3];
assign hit_b = wr_go && avs_address == `VCS_OFF_STAT_B &&
   avs_byteenable[3];
assign irq_clr = (wr_go && avs_address == `VCS_OFF_IRQ_CLR &&
   avs_byteenable[0]) ? avs_writedata[5:0] : 6'h00;
assign irq = |(irq_status & irq_enable);
vcs_channel u_a
(
   .clk(clk),
   .rst_b(rst_b),
   .ce(ce),
   .raw_mode(ctrl[0]),
   .hold_mode(ctrl[1]),
   .sync_line_select(a_sync_line_select),
   .field1_irq_line(a_field1_irq_line),
   .field2_irq_line(a_field2_irq_line),
   .pixel_counter(a_pixel_counter),
   .line_counter(a_line_counter),
   .sample_counter(a_sample_counter),
   .active_field(a_active_field),
   .frame_done(a_frame_done),
   .field1_done(a_field1_done),
   .field2_done(a_field2_done),
   .clr_wr(hit_a),
   .clr_bits(avs_writedata[30:28]),
   .status(stat_a),
   .done_pulse(pulse_a),
   .capture_allow(a_capture_allow)
);
vcs_channel u_b
(
   .clk(clk),
   .rst_b(rst_b),
   .ce(ce),
   .raw_mode(ctrl[2]),
   .hold_mode(ctrl[3]),
   .sync_line_select(b_sync_line_select),
   .field1_irq_line(b_field1_irq_line),
   .field2_irq_line(b_field2_irq_line),
   .pixel_counter(b_pixel_counter),
   .line_counter(b_line_counter),
   .sample_counter(b_sample_counter),
   .active_field(b_active_field),
   .frame_done(b_frame_done),
   .field1_done(b_field1_done),
   .field2_done(b_field2_done),
   .clr_wr(hit_b),
   .clr_bits(avs_writedata[30:28]),
   .status(stat_b),
   .done_pulse(pulse_b),
   .capture_allow(b_capture_allow)
);
always @(posedge clk)
begin
   if (!rst_b)
   begin
      ack <= 1'b0;
      ctrl <= 4'h0;
      irq_status <= 6'h00;
      irq_enable <= 6'h00;
      avs_readdata <= 32'h00000000;
   end
   else if (ce)
   begin
      ack <= req & ~ack;
      // new events beat a simultaneous clear
      irq_status <= (irq_status & ~irq_clr) | {pulse_b, pulse_a};
      if (wr_go && avs_address == `VCS_OFF_CTRL && avs_byteenable[0])
         ctrl <= avs_writedata[3:0];
      if (wr_go && avs_address == `VCS_OFF_IRQ_EN && avs_byteenable[0])
         irq_enable <= avs_writedata[5:0];
      if (rd_go)
      begin
         case (avs_address)
            `VCS_OFF_STAT_A: avs_readdata <= stat_a;
            `VCS_OFF_STAT_B: avs_readdata <= stat_b;
            `VCS_OFF_CTRL: avs_readdata <= {28'h0000000, ctrl};
            `VCS_OFF_IRQ_STAT: avs_readdata <= {26'h0, irq_status};
            `VCS_OFF_IRQ_EN: avs_readdata <= {26'h0, irq_enable};
            default: avs_readdata <= 32'h00000000;
         endcase
      end
   end
end
endmodule

// file: verification/vcs_chk.sv
// bus and status checks for the capture status bank
`timescale 1ns/1ps
module vcs_chk
(
   input wire clk,
   input wire rst_b,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire irq,
   input wire a_frame_done,
   input wire a_capture_allow
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire req = avs_read | avs_write;
   wire rd_end = avs_read & !avs_waitrequest;
   req_wait_a: assert property ($rose(req) |-> avs_waitrequest)
      else $error("no wait on a new request");
   ack_next_a: assert property ($rose(req) |=> !avs_waitrequest)
      else $error("answer not one cycle after request");
   idle_free_a: assert property (!req |-> !avs_waitrequest)
      else $error("wait raised with no request");
   resv_zero_a: assert property
      (rd_end |-> avs_readdata[15:13] == 3'h0)
      else $error("reserved bits read nonzero");
   unmap_zero_a: assert property (rd_end && avs_address > 4'h5
      |-> avs_readdata == 32'h0) else $error("unmapped read nonzero");
   rst_quiet_a: assert property
      ($rose(rst_b) |-> !irq && a_capture_allow)
      else $error("outputs not quiet after reset");
   frame_seen_a: assert property (rd_end && avs_address == 4'h0 &&
      $past(a_frame_done, 2) |-> avs_readdata[30]) else $error("frame lost");
   irq_fall_a: assert property ($fell(irq) |-> $past(avs_write))
      else $error("irq fell without a write");
   cover property (rd_end && avs_readdata[30]);
   cover property (rd_end && avs_readdata[31]);
   cover property ($rose(irq));
   cover property ($fell(irq));
endmodule
bind vcs_top vcs_chk i_chk (.*);

// file: verification/vcs_src.sv
// source model: running pixel, line and sample counts, done pulses
`timescale 1ns/1ps
module vcs_src
(
   input wire clk,
   input wire rst_b,
   input wire run,
   input wire allow,
   input wire [2:0] fire,
   output reg [11:0] pix,
   output reg [11:0] line,
   output reg [23:0] cnt,
   output wire fld,
   output reg frm,
   output reg f1,
   output reg f2
);
   assign fld = line[3];
   always @(posedge clk)
   begin
      // channel a takes no new frames while held; only its capture_allow gates the pulses
      {f2, f1, frm} <= fire & {3{allow}};
      if (!rst_b)
      begin
         pix <= 12'h0;
         line <= 12'h0;
         // starts below the 12-bit boundary so the upper half moves too
         cnt <= 24'h000f80;
      end
      else if (run)
      begin
         // sixteen pixels a line and sixteen lines a frame keep fields moving
         pix <= (pix == 12'hf) ? 12'h0 : pix + 12'h1;
         if (pix == 12'hf)
            line <= {8'h0, line[3:0] + 4'h1};
         cnt <= cnt + 24'h1;
      end
   end
endmodule

// file: verification/vcs_top_tb.sv
// bench for the capture status bank: bus, positions, flags, irq
`timescale 1ns/1ps
module vcs_top_tb;
   logic clk = 1'h0, rst_b = 1'h0, ce = 1'h1, avs_read = 1'h0;
   logic avs_write = 1'h0, run = 1'h0, a_sync_line_select = 1'h0;
   logic [2:0] fa = 3'h0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [11:0] a_field1_irq_line = 12'h3, a_field2_irq_line = 12'h5;
   logic [11:0] a_pixel_counter, a_line_counter;
   logic [23:0] a_sample_counter;
   logic a_active_field, a_frame_done, a_field1_done, a_field2_done;
   logic avs_waitrequest, irq, a_capture_allow, b_capture_allow;
   logic sync_exp;
   int mismatches = 0, num_checks = 0, m;
   always #20 clk = ~clk;
   // channel b shares the one source, so both words agree while both channels are set to the same mode
   vcs_top i_vcs_top (.*, .b_pixel_counter(a_pixel_counter),
      .b_line_counter(a_line_counter), .b_sample_counter(a_sample_counter),
      .b_active_field(a_active_field), .b_frame_done(a_frame_done),
      .b_field1_done(a_field1_done), .b_field2_done(a_field2_done),
      .b_field1_irq_line(a_field1_irq_line),
      .b_sync_line_select(a_sync_line_select),
      .b_field2_irq_line(a_field2_irq_line));
   vcs_src i_src (.clk, .rst_b, .run, .allow(a_capture_allow), .fire(fa),
      .pix(a_pixel_counter), .line(a_line_counter), .cnt(a_sample_counter),
      .fld(a_active_field), .frm(a_frame_done), .f1(a_field1_done),
      .f2(a_field2_done));
   function automatic logic [31:0] pos(input logic raw);
      return raw ? {4'h0, a_sample_counter[23:12], 4'h0,
         a_sample_counter[11:0]} : {sync_exp, 3'h0, a_line_counter, 3'h0,
         a_active_field, a_pixel_counter};
   endfunction
   // expected sync flag: set on line 1 of field 1, dropped at chosen line
   always @(posedge clk)
   begin
      if (!rst_b || m[0])
         sync_exp <= 1'h0;
      else if (a_line_counter == 12'h1 && !a_active_field)
         sync_exp <= 1'h1;
      else if (a_line_counter == (a_sync_line_select ? a_field2_irq_line :
         a_field1_irq_line))
         sync_exp <= 1'h0;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      while (avs_waitrequest !== 1'h0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 20) mismatches++;
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rst_check;
      rst_b <= 1'h0;
      run <= 1'h0;
      fa <= 3'h0;
      repeat (5) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      for (int i = 0; i < 5; i++)
      begin
         bus(1'h0, i == 4 ? 4'h9 : 4'(i), 32'h0);
         chk("reset word", 32'h0, rd);
      end
   endtask
   task summarize;
      if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      void'($urandom(20));
      rst_check();
      for (int i = 0; i < 8; i++)
      begin
         m = $urandom;
         a_sync_line_select <= m[1];
         bus(1'h1, 4'h2, m[0] ? 32'h5 : 32'h0);
         run <= 1'h1;
         repeat ($urandom_range(60, 3)) @(posedge clk);
         run <= 1'h0;
         repeat (3) @(posedge clk);
         // field bit has no meaning in raw mode, so it is masked there
         for (int c = 0; c < 2; c++)
         begin
            bus(1'h0, 4'(c), 32'h0);
            chk("position", pos(m[0]),
               m[0] ? rd & 32'hffffefff : rd);
         end
      end
      for (m = 1; m >= 0; m--)
      begin
         bus(1'h1, 4'h2, m[0] ? 32'h9 : 32'ha);
         bus(1'h1, 4'h4, m[0] ? 32'h0 : 32'h3f);
         fa <= 3'h7;
         @(posedge clk);
         fa <= 3'h0;
         repeat (2) @(posedge clk);
         bus(1'h1, 4'h0, 32'h8fffffff);
         bus(1'h0, 4'h0, 32'h0);
         chk("done flags",
            {29'h0, m[0] ? 3'h4 : 3'h7}, {29'h0, rd[30:28]});
         chk("irq hold", {29'h0, !m[0], m[0], 1'h0},
            {29'h0, irq, a_capture_allow, b_capture_allow});
         bus(1'h1, 4'h0, 32'h70000000);
         bus(1'h1, 4'h1, 32'h70000000);
         bus(1'h1, 4'h5, 32'h3f);
         bus(1'h0, 4'h0, 32'h0);
         chk("cleared", 32'h3,
            {26'h0, irq, rd[30:28], a_capture_allow, b_capture_allow});
      end
      // events that arrive while ce is low must leave no trace
      ce <= 1'h0;
      fa <= 3'h7;
      @(posedge clk);
      fa <= 3'h0;
      repeat (2) @(posedge clk);
      ce <= 1'h1;
      bus(1'h0, 4'h3, 32'h0);
      chk("frozen", 32'h0, rd);
      // set flags and irq, then reset in mid-run
      fa <= 3'h7;
      run <= 1'h1;
      @(posedge clk);
      fa <= 3'h0;
      repeat (2) @(posedge clk);
      rst_check();
      summarize();
   end
   initial
   begin
      #400000;
      mismatches++;
      summarize();
   end
endmodule
